//--- core/arpm_map.svh
`ifndef ARPM_MAP_SVH
`define ARPM_MAP_SVH

// ----------------------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------------------
`define ARPM_IDX_STATUS 6'h26
`define ARPM_IDX_ROUTE 6'h27
`define ARPM_IDX_ENABLE 6'h30
`define ARPM_IDX_CTRL 6'h31

// ----------------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------------
`define ARPM_ROUTE_MASK 24'hFF_FFFE
`define ARPM_SRC_MASK 24'hFF_FFFC
`define ARPM_CC_BIT 1
`define ARPM_CTRL_MODE_BIT 0
`define ARPM_CTRL_PIN_BIT 8
`define ARPM_CTRL_PEND_BIT 9
`define ARPM_CTRL_PULSE_BIT 10

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define ARPM_ROUTE_RESET 24'h00_0000
`define ARPM_ENABLE_RESET 24'h00_0000
`define ARPM_STATUS_RESET 24'h00_0000
`define ARPM_MODE_RESET 1'b0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define ARPM_CLK_MHZ 125
`define ARPM_CC_PULSE_NS 5000
`define ARPM_CC_PULSE_CYC ((`ARPM_CC_PULSE_NS * `ARPM_CLK_MHZ) / 1000)

`endif

//--- core/arpm_pkg.sv
package arpm_pkg;

  // Avalon-MM request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } arpm_avs_req_s;

  // State of the routing block, apart from the conversion-done pulse stretcher
  typedef struct packed {
    logic [23:0] route;
    logic [23:0] enable;
    logic [23:0] status;
    logic alert_mode;
    logic rd_pending;
    logic ack;
    logic [31:0] rdata;
    logic pin_drive;
    logic slow_req;
  } arpm_state_s;

  // State of the conversion-done pulse stretcher
  typedef struct packed {
    logic busy;
    logic [15:0] count;
  } arpm_pulse_s;

endpackage

//--- core/arpm_pulse.sv
`timescale 1ns/1ps
`include "arpm_map.svh"

module arpm_pulse #(
  parameter int CYCLES = `ARPM_CC_PULSE_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic trigger,
  output logic busy
);

  // Refuse lengths the 16-bit counter cannot hold
  if (CYCLES < 1 || CYCLES > 65535) begin : g_bad_cycles
    $error("arpm_pulse: CYCLES out of range");
  end

  localparam logic [15:0] LOAD = 16'(CYCLES - 1);

  arpm_pkg::arpm_pulse_s st_reg;
  arpm_pkg::arpm_pulse_s st_next;

  // Load on trigger, count down while busy; a retrigger restarts the pulse
  always_comb begin
    st_next = st_reg;
    if (trigger) begin
      st_next.busy = 1'b1;
      st_next.count = LOAD;
    end else if (st_reg.busy) begin
      if (st_reg.count == 16'h0000) begin
        st_next.busy = 1'b0;
      end else begin
        st_next.count = st_reg.count - 16'h0001;
      end
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy = st_reg.busy;

  // Helper: length of the current high phase
  logic [15:0] len_reg;
  always_ff @(posedge clock) begin
    if (rst || trigger) begin
      len_reg <= 16'h0000;
    end else if (st_reg.busy) begin
      len_reg <= len_reg + 16'h0001;
    end
  end

  property p_pulse_len;
    @(posedge clock) disable iff (rst)
    ($fell(busy) && !$past(trigger)) |-> (len_reg == 16'(CYCLES));
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse length wrong");

endmodule

//--- core/arpm_top.sv
// Contract
// - 24-bit RW routing register at 27h, resets zero, bit 0 reads zero.
// - Routing drives the pin only while the pin is in alert mode.
// - A routed source counts only when also enabled in the enable register; the conversion-end route (bit 1) needs no enable.
// - Bits 23..20 route overcurrent of channels 1..4.
// - Bits 19..16 route undercurrent of channels 1..4.
// - Bits 15..12 route overvoltage of channels 1..4.
// - Bits 11..8 route undervoltage of channels 1..4.
// - Bits 7..4 route overpower of channels 1..4.
// - Bit 3 routes accumulator full, bit 2 routes sample count full.
// - Bit 1 in alert mode pulses the pin 5 us per conversion end.
// - In alert mode the slow-sampling input function is unavailable.
// - Status clears after read plus conversion end, unless condition persists.
`timescale 1ns/1ps
`include "arpm_map.svh"

module arpm_top #(
  parameter int PULSE_CYCLES = `ARPM_CC_PULSE_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire arpm_pkg::arpm_avs_req_s avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [23:2] alert_cond,
  input wire logic conv_done,
  input wire logic first_alert_pin_i,
  output logic first_alert_pin_o,
  output logic first_alert_pin_oe,
  output logic slow_sample_req
);

  // --------------------------------------------------------------------------
  // Parameter check
  // --------------------------------------------------------------------------
  if (PULSE_CYCLES < 1 || PULSE_CYCLES > 65535) begin : g_bad_pulse
    $error("arpm_top: PULSE_CYCLES out of range");
  end

  localparam arpm_pkg::arpm_state_s RESET_STATE = '{
    route: `ARPM_ROUTE_RESET,
    enable: `ARPM_ENABLE_RESET,
    status: `ARPM_STATUS_RESET,
    alert_mode: `ARPM_MODE_RESET,
    rd_pending: 1'b0,
    ack: 1'b0,
    rdata: 32'h0000_0000,
    pin_drive: 1'b0,
    slow_req: 1'b0
  };

  // --------------------------------------------------------------------------
  // State and helpers
  // --------------------------------------------------------------------------
  arpm_pkg::arpm_state_s st_reg;
  arpm_pkg::arpm_state_s st_next;
  logic req;
  logic [5:0] idx;
  logic pulse_busy;
  logic pulse_trig;
  logic [23:0] cond;
  logic [23:0] qualified;
  logic alert_any;

  assign req = avs_req.read | avs_req.write;
  assign idx = avs_req.address[7:2];
  assign cond = {alert_cond, 2'b00} & st_reg.enable & `ARPM_SRC_MASK;
  assign qualified = st_reg.status & st_reg.enable & st_reg.route & `ARPM_SRC_MASK;
  assign pulse_trig = conv_done & st_reg.route[`ARPM_CC_BIT] & st_reg.alert_mode;
  // Any enabled, routed, tripped source, or the conversion-done pulse
  assign alert_any = (|qualified) | (pulse_busy & st_reg.route[`ARPM_CC_BIT]);

  // --------------------------------------------------------------------------
  // Conversion-done pulse stretcher
  // --------------------------------------------------------------------------
  arpm_pulse #(
    .CYCLES(PULSE_CYCLES)
  ) u_pulse (
    .clock(clock),
    .rst(rst),
    .trigger(pulse_trig),
    .busy(pulse_busy)
  );

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  // Bus access, status capture and pin drive
  always_comb begin
    st_next = st_reg;
    // One wait cycle: first cycle of a request is held, second is answered
    st_next.ack = req & ~st_reg.ack;
    if (req && !st_reg.ack && avs_req.read) begin
      case (idx)
        `ARPM_IDX_STATUS: st_next.rdata = {8'h00, st_reg.status & `ARPM_SRC_MASK};
        `ARPM_IDX_ROUTE: st_next.rdata = {8'h00, st_reg.route & `ARPM_ROUTE_MASK};
        `ARPM_IDX_ENABLE: st_next.rdata = {8'h00, st_reg.enable & `ARPM_SRC_MASK};
        `ARPM_IDX_CTRL: begin
          st_next.rdata = 32'h0000_0000;
          st_next.rdata[`ARPM_CTRL_MODE_BIT] = st_reg.alert_mode;
          st_next.rdata[`ARPM_CTRL_PIN_BIT] = st_reg.pin_drive;
          st_next.rdata[`ARPM_CTRL_PEND_BIT] = st_reg.rd_pending;
          st_next.rdata[`ARPM_CTRL_PULSE_BIT] = pulse_busy;
        end
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
    // Status: sticky, replaced by live conditions at a conversion end after a read
    if (st_reg.rd_pending && conv_done) begin
      st_next.status = cond;
      st_next.rd_pending = 1'b0;
    end else begin
      st_next.status = st_reg.status | cond;
    end
    // Answered cycle: writes land, a status read arms the clear
    if (req && st_reg.ack) begin
      if (avs_req.read && idx == `ARPM_IDX_STATUS) begin
        st_next.rd_pending = 1'b1;
      end
      if (avs_req.write) begin
        for (int i = 0; i < 3; i++) begin
          if (avs_req.byteenable[i]) begin
            if (idx == `ARPM_IDX_ROUTE) begin
              st_next.route[8*i +: 8] = avs_req.writedata[8*i +: 8];
            end
            if (idx == `ARPM_IDX_ENABLE) begin
              st_next.enable[8*i +: 8] = avs_req.writedata[8*i +: 8];
            end
          end
        end
        if (idx == `ARPM_IDX_CTRL && avs_req.byteenable[0]) begin
          st_next.alert_mode = avs_req.writedata[`ARPM_CTRL_MODE_BIT];
        end
        st_next.route = st_next.route & `ARPM_ROUTE_MASK;
        st_next.enable = st_next.enable & `ARPM_SRC_MASK;
      end
    end
    // Pin only obeys routing in alert mode
    st_next.pin_drive = st_reg.alert_mode & alert_any;
    // Slow-sampling input is ignored while the pin is an alert output
    st_next.slow_req = first_alert_pin_i & ~st_reg.alert_mode;
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg <= RESET_STATE;
    end else begin
      st_reg <= st_next;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Open-drain, active low: enable pulls the line low
  assign avs_waitrequest = req & ~st_reg.ack;
  assign avs_readdata = st_reg.rdata;
  assign first_alert_pin_o = 1'b0;
  assign first_alert_pin_oe = st_reg.pin_drive;
  assign slow_sample_req = st_reg.slow_req;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_route_read;
    (req && st_reg.ack && avs_req.read && idx == `ARPM_IDX_ROUTE) |->
      (avs_readdata[0] == 1'b0 && avs_readdata[31:24] == 8'h00);
  endproperty
  a_route_read: assert property (p_route_read) else $error("route readback bit 0 or top set");

  property p_route_write;
    (req && st_reg.ack && avs_req.write && idx == `ARPM_IDX_ROUTE && avs_req.byteenable[2]) |=>
      (st_reg.route[23:16] == $past(avs_req.writedata[23:16]));
  endproperty
  a_route_write: assert property (p_route_write) else $error("route write not stored");

  property p_mode_gate;
    !st_reg.alert_mode |=> !first_alert_pin_oe;
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("pin driven outside alert mode");

  property p_enable_gate;
    (((st_reg.enable & st_reg.route & `ARPM_SRC_MASK) == 24'h00_0000) && !st_reg.route[`ARPM_CC_BIT])
      |=> !first_alert_pin_oe;
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("pin driven with no enabled route");

  property p_source_drives;
    (st_reg.alert_mode && (|qualified)) |=> first_alert_pin_oe;
  endproperty
  a_source_drives: assert property (p_source_drives) else $error("routed source missed");

  property p_pin_cause;
    first_alert_pin_oe |-> $past(alert_any && st_reg.alert_mode);
  endproperty
  a_pin_cause: assert property (p_pin_cause) else $error("pin driven without cause");

  sequence s_cc_start;
    pulse_trig;
  endsequence
  sequence s_cc_hold;
    (st_reg.alert_mode && st_reg.route[`ARPM_CC_BIT])[*8];
  endsequence
  property p_cc_pulse;
    s_cc_start ##1 s_cc_hold |-> first_alert_pin_oe;
  endproperty
  a_cc_pulse: assert property (p_cc_pulse) else $error("conversion pulse missing");

  property p_slow_off;
    st_reg.alert_mode |=> !slow_sample_req;
  endproperty
  a_slow_off: assert property (p_slow_off) else $error("slow input active in alert mode");

  property p_status_clear;
    (st_reg.rd_pending && conv_done) |=> (st_reg.status == $past(cond));
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status not reloaded on conversion");

  property p_status_sticky;
    (!(st_reg.rd_pending && conv_done) && (|cond)) |=> ((st_reg.status & $past(cond)) == $past(cond));
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("status event lost");

  property p_wait_one;
    (req && !st_reg.ack) |-> avs_waitrequest ##1 (!req || !avs_waitrequest);
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer not after one wait cycle");

  // Every request starts with a wait cycle, so no answer can leak from the last one
  sequence s_new_req;
    !req ##1 req;
  endsequence
  property p_wait_first;
    s_new_req |-> avs_waitrequest;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("new request answered without wait");

  // Leaving reset the routing, enable and mode state is cleared
  property p_reset_zero;
    $fell(rst) |-> (st_reg.route == 24'h00_0000 && st_reg.enable == 24'h00_0000 && !st_reg.alert_mode);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("routing state not zero after reset");

  // Bit 0 of the routing register can never hold a one
  property p_route_bit0;
    !st_reg.route[0];
  endproperty
  a_route_bit0: assert property (p_route_bit0) else $error("route bit 0 set");

  // Readback of the routing register in the answered cycle
  sequence s_rd_wait;
    req && !st_reg.ack && avs_req.read && idx == `ARPM_IDX_ROUTE;
  endsequence
  sequence s_rd_take;
    avs_req.read && !avs_waitrequest;
  endsequence
  property p_route_readback;
    s_rd_wait ##1 s_rd_take |-> (avs_readdata == {8'h00, st_reg.route & `ARPM_ROUTE_MASK});
  endproperty
  a_route_readback: assert property (p_route_readback) else $error("route readback wrong");

  // Low byte of a routing write lands at the answer edge, bit 0 dropped
  sequence s_wr_wait;
    req && !st_reg.ack && avs_req.write && idx == `ARPM_IDX_ROUTE && avs_req.byteenable[0];
  endsequence
  sequence s_wr_take;
    avs_req.write && !avs_waitrequest;
  endsequence
  property p_route_lane0;
    s_wr_wait ##1 s_wr_take |=> (st_reg.route[7:0] == ($past(avs_req.writedata[7:0]) & 8'hFE));
  endproperty
  a_route_lane0: assert property (p_route_lane0) else $error("route low byte not stored");

  // Enable writes store the low byte with the two unused bits cleared
  property p_enable_lane0;
    (req && st_reg.ack && avs_req.write && idx == `ARPM_IDX_ENABLE && avs_req.byteenable[0]) |=>
      (st_reg.enable[7:0] == ($past(avs_req.writedata[7:0]) & 8'hFC));
  endproperty
  a_enable_lane0: assert property (p_enable_lane0) else $error("enable low byte not stored");

  // A status bit only rises from an enabled live condition
  property p_status_source;
    (st_reg.status & ~($past(st_reg.status) | $past(cond))) == 24'h00_0000;
  endproperty
  a_status_source: assert property (p_status_source) else $error("status set without condition");

  // An answered status read arms the clear, even beside a conversion end
  property p_pending_set;
    (req && st_reg.ack && avs_req.read && idx == `ARPM_IDX_STATUS) |=> st_reg.rd_pending;
  endproperty
  a_pending_set: assert property (p_pending_set) else $error("status read did not arm clear");

  // The armed clear waits for a conversion end
  property p_pending_hold;
    (st_reg.rd_pending && !conv_done) |=> st_reg.rd_pending;
  endproperty
  a_pending_hold: assert property (p_pending_hold) else $error("armed clear lost");

  // With nothing live at the conversion end the status empties
  sequence s_clear_edge;
    st_reg.rd_pending && conv_done && (cond == 24'h00_0000);
  endsequence
  property p_clear_zero;
    s_clear_edge |=> (st_reg.status == 24'h00_0000);
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("status not cleared");

  // The conversion pulse only starts from a trigger
  property p_pulse_start;
    (!pulse_busy && !pulse_trig) |=> !pulse_busy;
  endproperty
  a_pulse_start: assert property (p_pulse_start) else $error("pulse started without trigger");

  // A running pulse with its route set holds the pin in alert mode
  property p_pulse_pin;
    (pulse_busy && st_reg.route[`ARPM_CC_BIT] && st_reg.alert_mode) |=> first_alert_pin_oe;
  endproperty
  a_pulse_pin: assert property (p_pulse_pin) else $error("pulse not on pin");

  // Outside alert mode the pin level reaches the slow-sampling request
  property p_slow_pass;
    (!st_reg.alert_mode && first_alert_pin_i) |=> slow_sample_req;
  endproperty
  a_slow_pass: assert property (p_slow_pass) else $error("slow input not passed");

endmodule

//--- test/arpm_host_model.sv
`timescale 1ns/1ps
module arpm_host_model (
  input wire logic clock,
  input wire logic pin_o,
  input wire logic pin_oe,
  input wire logic slow_pull,
  output logic pin_level,
  output logic [15:0] low_len
);
  logic [15:0] run = 16'h0000;
  logic [15:0] last_len = 16'h0000;

  // ------------------------------------------------------------------
  // Open drain wire with pull-up, shared by device and host
  // ------------------------------------------------------------------
  assign pin_level = (pin_oe ? pin_o : 1'b1) & !slow_pull;

  // Width of the last low pulse seen by the host, in clock cycles
  assign low_len = last_len;
  always @(posedge clock) begin
    if (pin_level === 1'b0) begin
      run <= run + 16'h0001;
    end else begin
      if (run != 16'h0000) begin
        last_len <= run;
      end
      run <= 16'h0000;
    end
  end
endmodule

//--- test/tb_alert_pin1_routing_mask.sv
`timescale 1ns/1ps
module tb_alert_pin1_routing_mask;
  // ------------------------------------------------------------------
  // Bench signals
  // ------------------------------------------------------------------
  localparam int PULSE = 8;
  localparam logic [7:0] A_STAT = 8'h98;
  localparam logic [7:0] A_ROUTE = 8'h9C;
  localparam logic [7:0] A_EN = 8'hC0;
  localparam logic [7:0] A_CTRL = 8'hC4;
  logic clock = 1'b0;
  logic rst = 1'b1;
  arpm_pkg::arpm_avs_req_s avs_req = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [23:2] alert_cond = '0;
  logic conv_done = 1'b0;
  logic slow_pull = 1'b0;
  logic pin_level;
  logic pin_o;
  logic pin_oe;
  logic slow_req;
  logic [15:0] low_len;
  logic [31:0] rd;
  logic [3:0] be_sel = 4'hF;
  int n_errors = 0;
  int n_compared = 0;

  // Clock at 125 MHz
  always #4 clock = ~clock;

  arpm_top #(.PULSE_CYCLES(PULSE)) arpm_top_inst (.clock(clock), .rst(rst), .avs_req(avs_req),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .alert_cond(alert_cond),
    .conv_done(conv_done), .first_alert_pin_i(pin_level), .first_alert_pin_o(pin_o),
    .first_alert_pin_oe(pin_oe), .slow_sample_req(slow_req));

  arpm_host_model arpm_host_model_inst (.clock(clock), .pin_o(pin_o), .pin_oe(pin_oe),
    .slow_pull(slow_pull), .pin_level(pin_level), .low_len(low_len));

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  task automatic chkb(input string what, input logic exp, input logic got);
    chk(what, {31'h0000_0000, exp}, {31'h0000_0000, got});
  endtask

  // One Avalon transfer; request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic rdn, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    avs_req <= '{read: rdn, write: !rdn, address: a, writedata: wd, byteenable: be_sel};
    @(posedge clock);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge clock);
      n++;
    end
    if (n >= 50) chkb("waitrequest", 1'b0, 1'b1);
    rd = avs_readdata;
    avs_req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b1, a, 32'h0000_0000);
    chk(what, exp, rd);
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic conv;
    @(posedge clock);
    conv_done <= 1'b1;
    @(posedge clock);
    conv_done <= 1'b0;
  endtask

  task automatic cond(input logic [23:2] c);
    @(posedge clock);
    alert_cond <= c;
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_regs;
    rdc("route reset", A_ROUTE, 32'h0000_0000);
    wr(A_ROUTE, 32'hFFFF_FFFF);
    rdc("route all ones", A_ROUTE, 32'h00FF_FFFE);
    rdc("unmapped", 8'h04, 32'h0000_0000);
    wr(A_ROUTE, 32'h0000_0000);
    rdc("route zero", A_ROUTE, 32'h0000_0000);
    be_sel = 4'h4;
    wr(A_ROUTE, 32'hFFFF_FFFF);
    be_sel = 4'hF;
    rdc("route lane 2", A_ROUTE, 32'h00FF_0000);
    wr(A_STAT, 32'hFFFF_FFFF);
    rdc("status read only", A_STAT, 32'h0000_0000);
    $display("test regs done");
  endtask

  task automatic t_slow;
    wr(A_ROUTE, 32'h00FF_FFFC);
    wr(A_CTRL, 32'h0000_0001);
    cond('1);
    tick(4);
    chkb("routed not enabled", 1'b0, pin_oe);
    wr(A_CTRL, 32'h0000_0000);
    wr(A_EN, 32'h00FF_FFFC);
    rdc("enable", A_EN, 32'h00FF_FFFC);
    tick(4);
    chkb("slow mode pin", 1'b0, pin_oe);
    chkb("slow input high", 1'b1, slow_req);
    @(posedge clock);
    slow_pull <= 1'b1;
    tick(4);
    chkb("slow input low", 1'b0, slow_req);
    @(posedge clock);
    slow_pull <= 1'b0;
    wr(A_CTRL, 32'h0000_0001);
    tick(4);
    chkb("alert mode pin", 1'b1, pin_oe);
    rdc("ctrl", A_CTRL, 32'h0000_0301);
    cond('0);
    wr(A_EN, 32'h0000_0000);
    rdc("status all", A_STAT, 32'h00FF_FFFC);
    conv;
    tick(4);
    chkb("pin released", 1'b0, pin_oe);
    chkb("slow blocked", 1'b0, slow_req);
    $display("test slow done");
  endtask

  task automatic t_bits;
    logic [23:0] m;
    for (int b = 23; b >= 2; b--) begin
      m = 24'h00_0001 << b;
      wr(A_EN, 32'h0000_0000);
      wr(A_ROUTE, {8'h00, ~m & 24'hFF_FFFE});
      cond(m[23:2]);
      tick(4);
      chkb("disabled source", 1'b0, pin_oe);
      wr(A_EN, {8'h00, m});
      tick(4);
      chkb("routed elsewhere", 1'b0, pin_oe);
      wr(A_ROUTE, {8'h00, m});
      tick(4);
      chkb("routed bit", 1'b1, pin_oe);
      chkb("pin level", 1'b0, pin_level);
      cond('0);
      rdc("status bit", A_STAT, {8'h00, m});
      conv;
      tick(4);
      chkb("bit cleared", 1'b0, pin_oe);
    end
    $display("test bits done");
  endtask

  task automatic t_hold;
    wr(A_EN, 32'h0080_0000);
    wr(A_ROUTE, 32'h0080_0000);
    cond(22'h20_0000);
    tick(4);
    rdc("status held", A_STAT, 32'h0080_0000);
    conv;
    tick(4);
    chkb("still tripped", 1'b1, pin_oe);
    cond('0);
    rdc("status again", A_STAT, 32'h0080_0000);
    conv;
    tick(4);
    chkb("finally clear", 1'b0, pin_oe);
    $display("test hold done");
  endtask

  task automatic t_pulse;
    wr(A_EN, 32'h0000_0000);
    wr(A_ROUTE, 32'h0000_0002);
    conv;
    tick(PULSE + 6);
    chk("pulse length", 32'(PULSE), {16'h0000, low_len});
    wr(A_CTRL, 32'h0000_0000);
    conv;
    tick(4);
    chkb("no pulse in slow mode", 1'b0, pin_oe);
    $display("test pulse done");
  endtask

  task automatic t_reset;
    wr(A_ROUTE, 32'h00FF_FFFE);
    wr(A_CTRL, 32'h0000_0001);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rdc("route after reset", A_ROUTE, 32'h0000_0000);
    rdc("ctrl after reset", A_CTRL, 32'h0000_0000);
    chkb("pin after reset", 1'b0, pin_oe);
    $display("test reset done");
  endtask

  // ------------------------------------------------------------------
  // Verdict, main sequence and watchdog
  // ------------------------------------------------------------------
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Reset for three cycles, then the scenarios in turn
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    t_regs;
    t_slow;
    t_bits;
    t_hold;
    t_pulse;
    t_reset;
    complete_run;
  end

  // Cuts a hang short well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    complete_run;
  end
endmodule
